// ### rtl/tcp_pkg.sv
package tcp_pkg;
   // register offsets
   localparam logic [3:0] TCP_CTRL_ADDR = 4'h0;
   localparam logic [3:0] TCP_PER_ADDR  = 4'h1;
   localparam logic [3:0] TCP_CMP_ADDR  = 4'h2;
   localparam logic [3:0] TCP_CNT_ADDR  = 4'h3;
   localparam logic [3:0] TCP_CAP_ADDR  = 4'h4;
   localparam logic [3:0] TCP_DEAD_ADDR = 4'h5;
   localparam logic [3:0] TCP_STAT_ADDR = 4'h6;
   localparam logic [3:0] TCP_MASK_ADDR = 4'h7;
   // reset values
   localparam logic [15:0] TCP_PER_RST  = 16'hFFFF;
   localparam logic [15:0] TCP_CMP_RST  = 16'h8000;
   localparam logic [7:0]  TCP_DEAD_RST = 8'h00;
   // status and mask bit positions
   localparam int TCP_EV_TC  = 0;
   localparam int TCP_EV_CMP = 1;
   localparam int TCP_EV_CAP = 2;
   // counting modes
   typedef enum logic [1:0] {
      TCP_FREE_RUN = 2'b00,
      TCP_ONE_SHOT = 2'b01,
      TCP_GATED    = 2'b10
   } tcp_mode_t;
   // compare conditions
   typedef enum logic [2:0] {
      less_than_cmp        = 3'b000,
      less_or_equal_cmp    = 3'b001,
      same_value_cmp       = 3'b010,
      greater_or_equal_cmp = 3'b011,
      greater_than_cmp     = 3'b100
   } tcp_cmp_t;
   // control register layout, msb first
   typedef struct packed {
      logic      cpl_en;
      logic [1:0] clk_sel;
      tcp_cmp_t  cmp_sel;
      tcp_mode_t mode;
      logic      run;
   } tcp_ctrl_t;
   localparam tcp_ctrl_t TCP_CTRL_RST = '{1'b0, 2'b00, less_than_cmp, TCP_FREE_RUN, 1'b0};
endpackage

// ### rtl/tcp_timer.sv
// The address map and the plain strobed port were decided locally.
module tcp_timer
   import tcp_pkg::*;
#(
   parameter int DW = 16
)
(
   input  wire logic          ref_clk_in,
   input  wire logic          arst_n_in,
   input  wire logic [3:0]    addr_in,
   input  wire logic [DW-1:0] wdata_in,
   input  wire logic          we_in,
   input  wire logic          re_in,
   output logic [DW-1:0]      rdata_out,
   input  wire logic [2:0]    clk_src_in,
   input  wire logic          reset_in,
   input  wire logic          capture_in,
   input  wire logic          enable_in,
   input  wire logic          kill_in,
   output logic               cmp_out,
   output logic               cmp_n_out,
   output logic               tc_out,
   output logic               irq_out
);
   tcp_ctrl_t     ctrl_reg;
   logic [DW-1:0] per_reg;
   logic [DW-1:0] cmp_reg;
   logic [DW-1:0] cnt_reg;
   logic [DW-1:0] cap_reg;
   logic [7:0]    dead_reg;
   logic [7:0]    dcnt_reg;
   logic [2:0]    stat_reg;
   logic [2:0]    stat_next;
   logic [2:0]    mask_reg;
   logic [DW-1:0] rdata_reg;
   logic          run_q_reg;
   logic          active_reg;
   logic          cap_q_reg;
   logic          cmp_q_reg;
   logic          cmp_out_reg;
   logic          cmp_n_out_reg;
   logic          tc_reg;
   logic          irq_reg;
   logic          tick;
   logic          start_pls;
   logic          reload;
   logic          count_en;
   logic          at_zero;
   logic          cmp_raw;
   logic          cap_pls;
   logic [2:0]    ev;
   logic [3:0]    src_vec;

   // counting clock select, source 0 is every cycle
   assign src_vec   = {clk_src_in, 1'b1};
   assign tick      = src_vec[ctrl_reg.clk_sel];
   assign start_pls = ctrl_reg.run & ~run_q_reg;
   assign reload    = start_pls | reset_in;
   assign at_zero   = (cnt_reg == '0);
   // gate counting by mode and enable
   assign count_en  = active_reg & tick
                      & ((ctrl_reg.mode != TCP_GATED) | enable_in);
   assign cap_pls   = capture_in & ~cap_q_reg;

   // compare relation select
   always_comb
   begin
      case (ctrl_reg.cmp_sel)
         less_than_cmp:        cmp_raw = (cnt_reg <  cmp_reg);
         less_or_equal_cmp:    cmp_raw = (cnt_reg <= cmp_reg);
         same_value_cmp:       cmp_raw = (cnt_reg == cmp_reg);
         greater_or_equal_cmp: cmp_raw = (cnt_reg >= cmp_reg);
         greater_than_cmp:     cmp_raw = (cnt_reg >  cmp_reg);
         default:              cmp_raw = 1'b0;
      endcase
   end

   // interrupt events
   assign ev[TCP_EV_TC]  = count_en & at_zero & ~reload;
   // compare rise only while running, so reset raises no false edge
   assign ev[TCP_EV_CMP] = cmp_raw & ~cmp_q_reg & active_reg;
   assign ev[TCP_EV_CAP] = cap_pls;

   // register writes
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ctrl_reg <= TCP_CTRL_RST;
         per_reg  <= TCP_PER_RST;
         cmp_reg  <= TCP_CMP_RST;
         dead_reg <= TCP_DEAD_RST;
         mask_reg <= '0;
      end
      else if (we_in)
      begin
         if (addr_in == TCP_CTRL_ADDR)
            ctrl_reg <= tcp_ctrl_t'(wdata_in[$bits(tcp_ctrl_t)-1:0]);
         else if (addr_in == TCP_PER_ADDR)
            per_reg <= wdata_in;
         else if (addr_in == TCP_CMP_ADDR)
            cmp_reg <= wdata_in;
         else if (addr_in == TCP_DEAD_ADDR)
            dead_reg <= wdata_in[7:0];
         else if (addr_in == TCP_MASK_ADDR)
            mask_reg <= wdata_in[2:0];
      end
   end

   // sticky status, set wins over write-one clear
   always_comb
   begin
      stat_next = stat_reg;
      if (we_in && addr_in == TCP_STAT_ADDR)
         stat_next = stat_reg & ~wdata_in[2:0];
      stat_next = stat_next | ev;
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         stat_reg <= '0;
         irq_reg  <= 1'b0;
      end
      else
      begin
         stat_reg <= stat_next;
         irq_reg  <= |(stat_next & mask_reg);
      end
   end

   // read data, valid only the cycle after the strobe
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         rdata_reg <= '0;
      else if (!re_in)
         rdata_reg <= '0;
      else if (addr_in == TCP_CTRL_ADDR)
         rdata_reg <= DW'(ctrl_reg);
      else if (addr_in == TCP_PER_ADDR)
         rdata_reg <= per_reg;
      else if (addr_in == TCP_CMP_ADDR)
         rdata_reg <= cmp_reg;
      else if (addr_in == TCP_CNT_ADDR)
         rdata_reg <= cnt_reg;
      else if (addr_in == TCP_CAP_ADDR)
         rdata_reg <= cap_reg;
      else if (addr_in == TCP_DEAD_ADDR)
         rdata_reg <= DW'(dead_reg);
      else if (addr_in == TCP_STAT_ADDR)
         rdata_reg <= DW'(stat_reg);
      else if (addr_in == TCP_MASK_ADDR)
         rdata_reg <= DW'(mask_reg);
      else
         rdata_reg <= '0;
   end

   // run state, halts after one period in one shot
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         run_q_reg  <= 1'b0;
         active_reg <= 1'b0;
      end
      else
      begin
         run_q_reg <= ctrl_reg.run;
         if (!ctrl_reg.run)
            active_reg <= 1'b0;
         else if (start_pls)
            active_reg <= 1'b1;
         else if (ev[TCP_EV_TC] && ctrl_reg.mode == TCP_ONE_SHOT)
            active_reg <= 1'b0;
      end
   end

   // down counter with period reload
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         cnt_reg <= '0;
      else if (reload)
         cnt_reg <= per_reg;
      else if (count_en)
      begin
         if (!at_zero)
            cnt_reg <= cnt_reg - DW'(1);
         else if (ctrl_reg.mode != TCP_ONE_SHOT)
            cnt_reg <= per_reg;
      end
   end

   // terminal count held for one counting clock
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         tc_reg <= 1'b0;
      else if (ev[TCP_EV_TC])
         tc_reg <= 1'b1;
      else if (tick)
         tc_reg <= 1'b0;
   end

   // capture on rising edge of the capture input
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         cap_q_reg <= 1'b0;
         cap_reg   <= '0;
      end
      else
      begin
         cap_q_reg <= capture_in;
         if (cap_pls)
            cap_reg <= cnt_reg;
      end
   end

   // compare state and dead time counter
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         cmp_q_reg <= 1'b0;
         dcnt_reg  <= '0;
      end
      else
      begin
         cmp_q_reg <= cmp_raw;
         if (cmp_raw != cmp_q_reg)
            dcnt_reg <= dead_reg;
         else if (tick && dcnt_reg != '0)
            dcnt_reg <= dcnt_reg - 8'h01;
      end
   end

   // output stage with kill override
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         cmp_out_reg   <= 1'b0;
         cmp_n_out_reg <= 1'b0;
      end
      else if (kill_in)
      begin
         cmp_out_reg   <= 1'b0;
         cmp_n_out_reg <= 1'b0;
      end
      else if (ctrl_reg.cpl_en)
      begin
         cmp_out_reg   <= cmp_q_reg & (dcnt_reg == '0);
         cmp_n_out_reg <= ~cmp_q_reg & (dcnt_reg == '0);
      end
      else
      begin
         cmp_out_reg   <= cmp_q_reg;
         cmp_n_out_reg <= 1'b0;
      end
   end

   // outputs straight from flops
   assign rdata_out = rdata_reg;
   assign cmp_out   = cmp_out_reg;
   assign cmp_n_out = cmp_n_out_reg;
   assign tc_out    = tc_reg;
   assign irq_out   = irq_reg;

   // checks
   sequence s_dead_start;
      ctrl_reg.cpl_en && !kill_in && (cmp_raw != cmp_q_reg) && (dead_reg != 8'h00);
   endsequence

   sequence s_outs_quiet;
      !cmp_out_reg && !cmp_n_out_reg;
   endsequence

   AST_DOWN_ONLY: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (count_en && !at_zero && !reload) |=> (cnt_reg == $past(cnt_reg) - DW'(1)))
      else $error("counter did not step down by one");

   AST_RELOAD: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      reload |=> (cnt_reg == $past(per_reg)))
      else $error("period not reloaded on start or reset");

   AST_TC_PULSE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (count_en && at_zero && !reload) |=> tc_out)
      else $error("terminal count missing at zero");

   AST_ONE_SHOT: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (ev[TCP_EV_TC] && ctrl_reg.mode == TCP_ONE_SHOT) |=> (!active_reg && at_zero))
      else $error("one shot kept counting");

   AST_GATED_HOLD: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (ctrl_reg.mode == TCP_GATED && !enable_in && !reload) |=> $stable(cnt_reg))
      else $error("gated counter moved without enable");

   AST_KILL: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      kill_in |=> s_outs_quiet)
      else $error("kill did not silence outputs");

   AST_NO_OVERLAP: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !(cmp_out_reg && cmp_n_out_reg))
      else $error("complementary outputs both active");

   AST_DEAD_GAP: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      s_dead_start ##1 !kill_in |=> s_outs_quiet)
      else $error("no dead time after compare change");

   AST_CAPTURE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      $rose(capture_in) |=> (cap_reg == $past(cnt_reg)))
      else $error("capture value wrong");

   AST_IRQ: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (|(ev & mask_reg)) |=> irq_out)
      else $error("masked-in event did not raise interrupt");

   AST_CMP_STATUS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      ev[TCP_EV_CMP] |=> stat_reg[TCP_EV_CMP])
      else $error("compare event not recorded in status");

   AST_RDATA_IDLE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !re_in |=> (rdata_out == '0))
      else $error("read data not cleared after strobe");
endmodule

// ### bench/tcp_fabric.sv
// routing fabric stand-in: tick sources and registered control strobes
module tcp_fabric
(
   input  wire logic        ref_clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        capture_req_in,
   input  wire logic        kill_req_in,
   input  wire logic        enable_req_in,
   input  wire logic        reset_req_in,
   output logic [2:0]       clk_src_out,
   output logic             capture_out,
   output logic             kill_out,
   output logic             enable_out,
   output logic             reset_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] div_reg;
   // three tick sources at divide by 2, 3 and 4
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         div_reg     <= 4'h0;
         clk_src_out <= 3'h0;
      end
      else
      begin
         div_reg     <= (div_reg == 4'hB) ? 4'h0 : div_reg + 4'h1;
         clk_src_out <= {div_reg[1:0] == 2'h0, div_reg % 3 == 0, ~div_reg[0]};
      end
   end
   // strobes pass through one register stage like a synchronised route
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         {capture_out, kill_out, enable_out, reset_out} <= 4'h0;
      else
         {capture_out, kill_out, enable_out, reset_out} <=
            {capture_req_in, kill_req_in, enable_req_in, reset_req_in};
   end
endmodule

// ### bench/tb.sv
module tb;
   import tcp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, arst_n = 1'b0, we = 1'b0, re = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, v, x;
   logic [2:0]  clk_src;
   logic        cap_r = 1'b0, kill_r = 1'b0, en_r = 1'b0, rst_r = 1'b0;
   logic        cap, kill, en, rst, cmp_o, cmp_n, tc, irq;
   logic        saw_tc, saw_p, saw_n;
   int          bad_count = 0, total_checks = 0, cyc = 0, low_run = 0, min_gap = 99;
   logic [15:0] rst_tab [8] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h0000,
                                16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic [4:0]  rel_tab = 5'b01110;
   always #25 clk = ~clk;
   tcp_fabric u_tcp_fabric (.ref_clk_in(clk), .arst_n_in(arst_n), .capture_req_in(cap_r),
      .kill_req_in(kill_r), .enable_req_in(en_r), .reset_req_in(rst_r), .clk_src_out(clk_src),
      .capture_out(cap), .kill_out(kill), .enable_out(en), .reset_out(rst));
   tcp_timer u_tcp_timer (.ref_clk_in(clk), .arst_n_in(arst_n), .addr_in(addr),
      .wdata_in(wdata), .we_in(we), .re_in(re), .rdata_out(rdata), .clk_src_in(clk_src),
      .reset_in(rst), .capture_in(cap), .enable_in(en), .kill_in(kill), .cmp_out(cmp_o),
      .cmp_n_out(cmp_n), .tc_out(tc), .irq_out(irq));
   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      we <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask
   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      re <= 1'b1; addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc >= 20000)
      begin
         bad_count++;
         final_report();
      end
   end
   // complementary pair watch: overlap and dead gap
   always @(posedge clk)
   begin
      if (cmp_o === 1'b1 && cmp_n === 1'b1)
         chk("overlap", 16'h0, 16'h1);
      saw_p = saw_p | (cmp_o === 1'b1);
      saw_n = saw_n | (cmp_n === 1'b1);
      if (cmp_o === 1'b0 && cmp_n === 1'b0)
         low_run++;
      else
      begin
         if (low_run > 0 && saw_n && low_run < min_gap)
            min_gap = low_run;
         low_run = 0;
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      // reset values and an unmapped index
      for (int i = 0; i < 9; i++)
      begin
         rd(i[3:0], v);
         chk("reset reg", (i < 8) ? rst_tab[i] : 16'h0000, v);
      end
      // gated mode: start reloads, counts only with enable
      wr(TCP_PER_ADDR, 16'h0100);
      wr(TCP_CMP_ADDR, 16'h0100);
      wr(TCP_CTRL_ADDR, 16'h0005);
      repeat (4) @(posedge clk);
      rd(TCP_CNT_ADDR, v);
      chk("gated start", 16'h0100, v);
      en_r <= 1'b1;
      repeat (10) @(posedge clk);
      en_r <= 1'b0;
      repeat (3) @(posedge clk);
      rd(TCP_CNT_ADDR, x);
      chk("gated counted", 16'h1, {15'h0, x < 16'h0100 && x > 16'h00F0});
      rd(TCP_CNT_ADDR, v);
      chk("gated hold", x, v);
      // capture of a held counter
      cap_r <= 1'b1;
      repeat (3) @(posedge clk);
      cap_r <= 1'b0;
      rd(TCP_CAP_ADDR, v);
      chk("capture", x, v);
      rd(TCP_STAT_ADDR, v);
      chk("cap status", 16'h0004, v & 16'h0004);
      // reset input reloads period
      rst_r <= 1'b1;
      repeat (3) @(posedge clk);
      rst_r <= 1'b0;
      rd(TCP_CNT_ADDR, v);
      chk("reset reload", 16'h0100, v);
      // five compare relations with counter equal to compare value
      for (int i = 0; i < 5; i++)
      begin
         wr(TCP_CTRL_ADDR, 16'h0005 | 16'(i << 3));
         repeat (4) @(posedge clk);
         chk("relation", {15'h0, rel_tab[i]}, {15'h0, cmp_o});
         chk("no cpl", 16'h0, {15'h0, cmp_n});
      end
      // kill forces compare low, release restores
      wr(TCP_CTRL_ADDR, 16'h001D);
      kill_r <= 1'b1;
      repeat (3) @(posedge clk);
      chk("killed", 16'h0, {15'h0, cmp_o});
      kill_r <= 1'b0;
      repeat (4) @(posedge clk);
      chk("unkilled", 16'h1, {15'h0, cmp_o});
      // mask gates the interrupt, write one clears
      chk("masked irq", 16'h0, {15'h0, irq});
      wr(TCP_MASK_ADDR, 16'h0007);
      repeat (2) @(posedge clk);
      chk("unmasked irq", 16'h1, {15'h0, irq});
      wr(TCP_STAT_ADDR, 16'h0007);
      repeat (2) @(posedge clk);
      chk("cleared irq", 16'h0, {15'h0, irq});
      // free run period 2: terminal count one cycle wide
      wr(TCP_CTRL_ADDR, 16'h0000);
      wr(TCP_PER_ADDR, 16'h0002);
      wr(TCP_CTRL_ADDR, 16'h0001);
      saw_tc = 1'b0;
      for (int i = 0; i < 20 && !saw_tc; i++)
      begin
         @(posedge clk);
         #1 saw_tc = (tc === 1'b1);
      end
      chk("tc seen", 16'h1, {15'h0, saw_tc});
      @(posedge clk);
      #1 chk("tc width", 16'h0, {15'h0, tc});
      rd(TCP_STAT_ADDR, v);
      chk("tc status", 16'h0001, v & 16'h0001);
      wr(TCP_CNT_ADDR, 16'h1234);
      rd(TCP_CNT_ADDR, v);
      chk("running read", 16'h1, {15'h0, v <= 16'h0002});
      // one shot stops at zero
      wr(TCP_CTRL_ADDR, 16'h0000);
      wr(TCP_PER_ADDR, 16'h0005);
      wr(TCP_CTRL_ADDR, 16'h0003);
      repeat (20) @(posedge clk);
      rd(TCP_CNT_ADDR, v);
      chk("one shot", 16'h0000, v);
      rd(TCP_CNT_ADDR, v);
      chk("one shot held", 16'h0000, v);
      chk("one shot tc", 16'h0, {15'h0, tc});
      // tick sources two and three set the counting rate
      wr(TCP_PER_ADDR, 16'h0100);
      for (int s = 2; s < 4; s++)
      begin
         wr(TCP_CTRL_ADDR, 16'h0000);
         wr(TCP_CTRL_ADDR, 16'h0001 | 16'(s << 6));
         repeat (60) @(posedge clk);
         rd(TCP_CNT_ADDR, v);
         x = (s == 2) ? 16'h00EA : 16'h00EF;
         chk("tick rate", 16'h1, {15'h0, v >= x && v <= x + 16'h0003});
      end
      // complementary pair on tick source 1 with dead time 3
      wr(TCP_CTRL_ADDR, 16'h0000);
      wr(TCP_PER_ADDR, 16'h0014);
      wr(TCP_CMP_ADDR, 16'h000A);
      wr(TCP_DEAD_ADDR, 16'h0003);
      saw_p = 1'b0;
      saw_n = 1'b0;
      wr(TCP_CTRL_ADDR, 16'h0141);
      repeat (300) @(posedge clk);
      chk("cpl seen", 16'h3, {14'h0, saw_p, saw_n});
      chk("dead gap", 16'h1, {15'h0, min_gap >= 3 && min_gap < 99});
      final_report();
   end
endmodule
